// [inc/glp_pkg.sv]
// Constants, codes and carrier structs for the low pin function select block.
// Assumes a single 50 MHz clock and an APB register bus with 32-bit data.
package glp_pkg;

    localparam int GLP_PINS      = 8;
    localparam int GLP_SCRATCH_N = 16;
    localparam int GLP_FIELD_W   = 2;
    localparam int GLP_REG_W     = 16;

    // Register indices; the byte address is four times the index
    localparam logic [27:0] GLP_MODE_IDX = 28'hb00_0300;
    localparam logic [27:0] GLP_SCRATCH_IDX [GLP_SCRATCH_N] = '{
        28'hb00_0330, 28'hb00_0332, 28'hb00_0334, 28'hb00_0336,
        28'hb00_0338, 28'hb00_033a, 28'hb00_033c, 28'hb00_033d,
        28'hb00_0340, 28'hb00_0342, 28'hb00_0344, 28'hb00_0346,
        28'hb00_0348, 28'hb00_034a, 28'hb00_034c, 28'hb00_034e
    };

    // Reset values
    localparam logic [15:0] GLP_MODE_RESET    = 16'h0000;
    localparam logic [15:0] GLP_SCRATCH_RESET = 16'h0000;
    localparam logic [31:0] GLP_RDATA_IDLE    = 32'h0000_0000;

    // Pins that carry an alternate function, plus pin 4, which has none
    localparam int GLP_PIN_TERM_READY = 7;
    localparam int GLP_PIN_REQ_SEND   = 6;
    localparam int GLP_PIN_CARRIER    = 5;
    localparam int GLP_PIN_PLAIN      = 4;
    localparam int GLP_PIN_CHIP_SEL   = 3;
    localparam int GLP_PIN_CSI_SCK    = 2;
    localparam int GLP_PIN_CSI_SO     = 1;
    localparam int GLP_PIN_CSI_SI     = 0;

    // Two-bit function field codes
    typedef enum logic [1:0] {
        GLP_GP_IN  = 2'b00,
        GLP_ALT_01 = 2'b01,
        GLP_GP_OUT = 2'b10,
        GLP_ALT_11 = 2'b11
    } glp_mode_e;

    // APB request as the master drives it
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } glp_apb_req_s;

    // Peripheral outputs that may be routed onto pins
    typedef struct packed {
        logic aux_serial_terminal_ready_n;
        logic aux_serial_request_send_n;
        logic chip_select0_n;
        logic csi_serial_out;
    } glp_alt_out_s;

    // Pin levels handed to peripheral inputs
    typedef struct packed {
        logic aux_serial_carrier_detect_n;
        logic csi_serial_clock;
        logic csi_serial_in;
    } glp_alt_in_s;

    localparam glp_alt_in_s GLP_ALT_IN_IDLE = '{1'b1, 1'b0, 1'b0};

endpackage

// [verilog/glp_scratch_mem.sv]
// Sixteen 16-bit battery-backed scratch words with a registered read port.
// Assumes the same clock as the bus slave; only the RTC-domain reset clears it.
`timescale 1ns/1ps
`default_nettype none
module glp_scratch_mem (
    input  wire logic        core_clk_i,
    input  wire logic        rtc_domain_reset_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic        wr_en_i,
    input  wire logic [1:0]  wr_be_i,
    input  wire logic [15:0] wr_data_i,
    output logic      [15:0] rd_data_o
);

    typedef struct packed {
        logic [glp_pkg::GLP_SCRATCH_N-1:0][15:0] cells;
        logic [15:0]                             rd_data;
    } glp_mem_state_s;

    glp_mem_state_s mem_reg;
    glp_mem_state_s mem_next;

    // Other resets leave the words alone, as the battery keeps them
    always_comb begin
        mem_next         = mem_reg;
        mem_next.rd_data = mem_reg.cells[addr_i];
        if (wr_en_i) begin
            if (wr_be_i[0]) begin
                mem_next.cells[addr_i][7:0] = wr_data_i[7:0];
            end
            if (wr_be_i[1]) begin
                mem_next.cells[addr_i][15:8] = wr_data_i[15:8];
            end
        end
        if (rtc_domain_reset_i) begin
            for (int i = 0; i < glp_pkg::GLP_SCRATCH_N; i++) begin
                mem_next.cells[i] = glp_pkg::GLP_SCRATCH_RESET;
            end
            mem_next.rd_data = glp_pkg::GLP_SCRATCH_RESET;
        end
    end

    always_ff @(posedge core_clk_i) begin
        mem_reg <= mem_next;
    end

    assign rd_data_o = mem_reg.rd_data;

endmodule // glp_scratch_mem
`default_nettype wire

// [verilog/glp_pin_function_select.sv]
// Function select for general pins 0..7 plus the scratch word bank, APB slave.
// Assumes pins arrive asynchronously; peripheral and data inputs share core_clk_i.
//
// Notes on behaviour
// RULE_01 - Field 00 makes the pin an input; 10 drives it as output.
// RULE_02 - Pin n owns mode bits 2n+1:2n, upper bit first.
// RULE_03 - Pin 7 with 11 carries aux serial terminal ready; 01 reserved.
// RULE_04 - Pin 6 with 11 carries aux serial request to send; 01 reserved.
// RULE_05 - Pin 5 with 01 feeds aux serial carrier detect; 11 reserved.
// RULE_06 - Pin 4 is plain input or output only; 01 and 11 reserved.
// RULE_07 - Pin 3 with 11 drives programmable chip select 0; 01 reserved.
// RULE_08 - Pin 2 with 01 feeds the clocked serial clock input; 11 reserved.
// RULE_09 - Pin 1 with 11 drives clocked serial data output; 01 reserved.
// RULE_10 - Pin 0 with 01 feeds clocked serial data input; 11 reserved.
// RULE_11 - Sixteen readable, writable scratch words kept by the backup battery.
// RULE_12 - Resets other than RTC reset keep the mode register contents.
// RULE_13 - RTC reset clears every function field to 00, all pins inputs.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module glp_pin_function_select (
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_i,
    input  wire logic                  rtc_domain_reset_i,
    input  wire glp_pkg::glp_apb_req_s apb_req_i,
    output logic                       pready_o,
    output logic [31:0]                prdata_o,
    output logic                       pslverr_o,
    input  wire logic [7:0]            pin_in_i,
    output logic      [7:0]            pin_out_o,
    output logic      [7:0]            pin_oe_n_o,
    input  wire logic [7:0]            gp_out_data_i,
    output logic      [7:0]            gp_in_data_o,
    input  wire glp_pkg::glp_alt_out_s alt_out_i,
    output glp_pkg::glp_alt_in_s       alt_in_o
);

    typedef struct packed {
        logic [15:0]          mode;
        logic                 pready;
        logic                 pslverr;
        logic [31:0]          prdata;
        logic [7:0]           pin_meta;
        logic [7:0]           pin_sync;
        logic [7:0]           pin_out;
        logic [7:0]           pin_oe_n;
        glp_pkg::glp_alt_in_s alt_in;
    } glp_state_s;

    glp_state_s state_reg;
    glp_state_s state_next;

    logic        hit_mode;
    logic        hit_scratch;
    logic [3:0]  scratch_idx;
    logic [15:0] scratch_rd;
    logic        access_wait;
    logic        access_end;
    logic        scratch_wr;

    // Address decode; each word sits at four times its register index
    always_comb begin
        hit_mode    = (apb_req_i.paddr == {2'b00, glp_pkg::GLP_MODE_IDX, 2'b00});
        hit_scratch = 1'b0;
        scratch_idx = 4'h0;
        for (int i = 0; i < glp_pkg::GLP_SCRATCH_N; i++) begin
            if (apb_req_i.paddr == {2'b00, glp_pkg::GLP_SCRATCH_IDX[i], 2'b00}) begin
                hit_scratch = 1'b1;
                scratch_idx = 4'(i);
            end
        end
    end

    // First access cycle prepares the answer, second one completes it
    assign access_wait = apb_req_i.psel & apb_req_i.penable & ~state_reg.pready;
    assign access_end  = apb_req_i.psel & apb_req_i.penable & state_reg.pready;

    // Scratch writes land on the completing edge only, never during reset
    assign scratch_wr = access_end & apb_req_i.pwrite & hit_scratch & ~reset_i;

    // Scratch bank; read data for the held address is valid one edge later
    glp_scratch_mem u_scratch (
        .core_clk_i         (core_clk_i),
        .rtc_domain_reset_i (rtc_domain_reset_i),
        .addr_i             (scratch_idx),
        .wr_en_i            (scratch_wr),
        .wr_be_i            (apb_req_i.pstrb[1:0]),
        .wr_data_i          (apb_req_i.pwdata[15:0]),
        .rd_data_o          (scratch_rd)
    ); // see RULE_11

    // Next-state logic: bus slave, mode register, pin routing
    always_comb begin
        glp_pkg::glp_mode_e fld [glp_pkg::GLP_PINS];
        fld        = '{default: glp_pkg::GLP_GP_IN};
        state_next = state_reg;
        for (int p = 0; p < glp_pkg::GLP_PINS; p++) begin
            fld[p] = glp_pkg::glp_mode_e'(state_reg.mode[p*2 +: 2]); // see RULE_02
        end

        // Bus answer: registered, one wait cycle after the setup phase
        if (access_wait) begin
            state_next.pready  = 1'b1;
            state_next.pslverr = ~(hit_mode | hit_scratch);
            if (hit_mode) begin
                state_next.prdata = {16'h0000, state_reg.mode};
            end else if (hit_scratch) begin
                state_next.prdata = {16'h0000, scratch_rd}; // see RULE_11
            end else begin
                state_next.prdata = glp_pkg::GLP_RDATA_IDLE;
            end
        end else if (access_end) begin
            state_next.pready  = 1'b0;
            state_next.pslverr = 1'b0;
            state_next.prdata  = glp_pkg::GLP_RDATA_IDLE;
        end

        // Mode register write, byte lanes 0 and 1; upper lanes ignored
        if (access_end && apb_req_i.pwrite && hit_mode) begin
            if (apb_req_i.pstrb[0]) begin
                state_next.mode[7:0] = apb_req_i.pwdata[7:0]; // see RULE_02
            end
            if (apb_req_i.pstrb[1]) begin
                state_next.mode[15:8] = apb_req_i.pwdata[15:8]; // see RULE_02
            end
        end

        // Two-stage synchroniser for the pad levels
        state_next.pin_meta = pin_in_i;
        state_next.pin_sync = state_reg.pin_meta;

        // Default per pin: plain input or plain output
        for (int p = 0; p < glp_pkg::GLP_PINS; p++) begin
            if (fld[p] == glp_pkg::GLP_GP_OUT) begin
                state_next.pin_out[p]  = gp_out_data_i[p]; // see RULE_01
                state_next.pin_oe_n[p] = 1'b0;             // see RULE_01
            end else begin
                // Input, reserved code, or input-type alternate: pad released
                state_next.pin_out[p]  = 1'b0;             // see RULE_01
                state_next.pin_oe_n[p] = 1'b1;             // see RULE_01
            end
        end

        // Pin 7: terminal ready on code 11
        if (fld[glp_pkg::GLP_PIN_TERM_READY] == glp_pkg::GLP_ALT_11) begin
            state_next.pin_out[glp_pkg::GLP_PIN_TERM_READY]  =
                alt_out_i.aux_serial_terminal_ready_n;     // see RULE_03
            state_next.pin_oe_n[glp_pkg::GLP_PIN_TERM_READY] = 1'b0; // see RULE_03
        end

        // Pin 6: request to send on code 11
        if (fld[glp_pkg::GLP_PIN_REQ_SEND] == glp_pkg::GLP_ALT_11) begin
            state_next.pin_out[glp_pkg::GLP_PIN_REQ_SEND]  =
                alt_out_i.aux_serial_request_send_n;       // see RULE_04
            state_next.pin_oe_n[glp_pkg::GLP_PIN_REQ_SEND] = 1'b0; // see RULE_04
        end

        // Pin 4 has no alternate, so both odd codes leave it released
        // see RULE_06

        // Pin 3: chip select 0 on code 11
        if (fld[glp_pkg::GLP_PIN_CHIP_SEL] == glp_pkg::GLP_ALT_11) begin
            state_next.pin_out[glp_pkg::GLP_PIN_CHIP_SEL]  =
                alt_out_i.chip_select0_n;                  // see RULE_07
            state_next.pin_oe_n[glp_pkg::GLP_PIN_CHIP_SEL] = 1'b0; // see RULE_07
        end

        // Pin 1: clocked serial data out on code 11
        if (fld[glp_pkg::GLP_PIN_CSI_SO] == glp_pkg::GLP_ALT_11) begin
            state_next.pin_out[glp_pkg::GLP_PIN_CSI_SO]  =
                alt_out_i.csi_serial_out;                  // see RULE_09
            state_next.pin_oe_n[glp_pkg::GLP_PIN_CSI_SO] = 1'b0; // see RULE_09
        end

        // Peripheral inputs: idle level unless the pin is routed to them
        state_next.alt_in = glp_pkg::GLP_ALT_IN_IDLE;
        if (fld[glp_pkg::GLP_PIN_CARRIER] == glp_pkg::GLP_ALT_01) begin
            state_next.alt_in.aux_serial_carrier_detect_n =
                state_reg.pin_sync[glp_pkg::GLP_PIN_CARRIER]; // see RULE_05
        end
        if (fld[glp_pkg::GLP_PIN_CSI_SCK] == glp_pkg::GLP_ALT_01) begin
            state_next.alt_in.csi_serial_clock =
                state_reg.pin_sync[glp_pkg::GLP_PIN_CSI_SCK]; // see RULE_08
        end
        if (fld[glp_pkg::GLP_PIN_CSI_SI] == glp_pkg::GLP_ALT_01) begin
            state_next.alt_in.csi_serial_in =
                state_reg.pin_sync[glp_pkg::GLP_PIN_CSI_SI];  // see RULE_10
        end

        // Any reset: bus idle, pads released; mode survives a plain reset
        if (reset_i || rtc_domain_reset_i) begin
            state_next.pready   = 1'b0;
            state_next.pslverr  = 1'b0;
            state_next.prdata   = glp_pkg::GLP_RDATA_IDLE;
            state_next.pin_meta = 8'h00;
            state_next.pin_sync = 8'h00;
            state_next.pin_out  = 8'h00;
            state_next.pin_oe_n = 8'hff;
            state_next.alt_in   = glp_pkg::GLP_ALT_IN_IDLE;
        end                                                   // see RULE_12
        // Only the RTC-domain reset brings every pin back to input
        if (rtc_domain_reset_i) begin
            state_next.mode = glp_pkg::GLP_MODE_RESET;        // see RULE_13
        end
    end

    // The only state register of this module
    always_ff @(posedge core_clk_i) begin
        state_reg <= state_next;
    end

    // Every output comes straight from a flop
    assign pready_o     = state_reg.pready;
    assign prdata_o     = state_reg.prdata;
    assign pslverr_o    = state_reg.pslverr;
    assign pin_out_o    = state_reg.pin_out;
    assign pin_oe_n_o   = state_reg.pin_oe_n;
    assign gp_in_data_o = state_reg.pin_sync;
    assign alt_in_o     = state_reg.alt_in;

endmodule // glp_pin_function_select
`default_nettype wire

// [dv/glp_props.sv]
// Port-level checks for the low pin function select block.
// Assumes a bind onto the top module; keeps its own copy of the mode word from bus writes.
`timescale 1ns/1ps
`default_nettype none
module glp_props (
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_i,
    input  wire logic                  rtc_domain_reset_i,
    input  wire glp_pkg::glp_apb_req_s apb_req_i,
    input  wire logic                  pready_o,
    input  wire logic [31:0]           prdata_o,
    input  wire logic                  pslverr_o,
    input  wire logic [7:0]            pin_in_i,
    input  wire logic [7:0]            pin_out_o,
    input  wire logic [7:0]            pin_oe_n_o,
    input  wire logic [7:0]            gp_out_data_i,
    input  wire logic [7:0]            gp_in_data_o,
    input  wire glp_pkg::glp_alt_out_s alt_out_i,
    input  wire glp_pkg::glp_alt_in_s  alt_in_o
);
    logic [15:0] m;
    logic [2:0]  quiet;
    logic        rst;
    logic        hit;
    assign rst = reset_i | rtc_domain_reset_i;
    assign hit = apb_req_i.psel & apb_req_i.penable & pready_o;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst);

    // Mirror of the mode word; only the RTC reset clears it, byte strobes gate halves
    always_ff @(posedge core_clk_i) begin
        if (rtc_domain_reset_i) begin
            m <= 16'h0000;
        end else if (hit && apb_req_i.pwrite && apb_req_i.paddr == {2'b00, glp_pkg::GLP_MODE_IDX, 2'b00}) begin
            m <= {apb_req_i.pstrb[1] ? apb_req_i.pwdata[15:8] : m[15:8],
                  apb_req_i.pstrb[0] ? apb_req_i.pwdata[7:0] : m[7:0]};
        end
    end

    // Cycles since reset or any write; the input paths need a few quiet edges to settle
    always_ff @(posedge core_clk_i) begin
        if (rst || (hit && apb_req_i.pwrite)) begin
            quiet <= 3'h0;
        end else if (quiet != 3'h7) begin
            quiet <= quiet + 3'h1;
        end
    end

    function automatic logic mapped(input logic [31:0] a);
        mapped = (a == {2'b00, glp_pkg::GLP_MODE_IDX, 2'b00});
        for (int i = 0; i < 16; i++) begin
            mapped = mapped | (a == {2'b00, glp_pkg::GLP_SCRATCH_IDX[i], 2'b00});
        end
    endfunction

    // Pins 7, 6, 3 and 1 are the only ones with an alternate output on code 11
    function automatic logic [15:0] drive_f(input logic [15:0] v, input logic [7:0] g, input logic [3:0] a);
        logic [7:0] oe;
        logic [7:0] o;
        logic [7:0] alt;
        alt = {a[3], a[2], 2'b00, a[1], 1'b0, a[0], 1'b0};
        for (int n = 0; n < 8; n++) begin
            oe[n] = !(v[2*n+:2] == 2'h2 || (v[2*n+:2] == 2'h3 && (8'hca >> n & 1'b1)));
            o[n]  = (v[2*n+:2] == 2'h2) ? g[n] : (v[2*n+:2] == 2'h3 && (8'hca >> n & 1'b1)) ? alt[n] : 1'b0;
        end
        return {oe, o};
    endfunction

    sequence s_setup;
        apb_req_i.psel && !apb_req_i.penable;
    endsequence
    sequence s_ready;
        apb_req_i.penable && !pready_o ##1 apb_req_i.penable && pready_o;
    endsequence

    chk_one_wait:
    assert property (s_setup |=> s_ready) else $error("access did not end after one wait");
    chk_ready_once:
    assert property (pready_o |=> !pready_o) else $error("ready held past one cycle");
    chk_addr_err:
    assert property (pready_o |-> pslverr_o == !mapped(apb_req_i.paddr) && (mapped(apb_req_i.paddr) || prdata_o == 32'h0000_0000))
        else $error("error flag or data wrong for address");
    chk_mode_read:
    assert property (pready_o && !apb_req_i.pwrite && apb_req_i.paddr == {2'b00, glp_pkg::GLP_MODE_IDX, 2'b00}
        |-> prdata_o == {16'h0000, m}) else $error("mode word read back wrong");
    chk_oe_map:
    assert property (!$past(rst) |-> pin_oe_n_o == 8'(drive_f($past(m), 8'h00, 4'h0) >> 8))
        else $error("pad enables wrong");
    chk_out_map:
    assert property (!$past(rst) |-> pin_out_o == 8'(drive_f($past(m), $past(gp_out_data_i), $past(alt_out_i))))
        else $error("pad output levels wrong");
    chk_in_sync:
    assert property (quiet > 3'h3 |-> gp_in_data_o == $past(pin_in_i, 2)) else $error("input data not two edges behind");
    chk_alt_inputs:
    assert property (quiet > 3'h4 |-> alt_in_o == {(m[11:10] == 2'h1) ? $past(pin_in_i[5], 3) : 1'b1,
        (m[5:4] == 2'h1) & $past(pin_in_i[2], 3), (m[1:0] == 2'h1) & $past(pin_in_i[0], 3)})
        else $error("peripheral inputs routed wrong");
endmodule // glp_props
`default_nettype wire

// [dv/glp_pad_model.sv]
// Pads and peripherals outside the block: pads read back when driven, else outside levels.
// Assumes the bench supplies outside levels and peripheral outputs on the core clock.
`timescale 1ns/1ps
`default_nettype none
module glp_pad_model (
    input  wire logic                  core_clk_i,
    input  wire logic [7:0]            ext_level_i,
    input  wire logic [3:0]            periph_i,
    input  wire logic [7:0]            pin_out_i,
    input  wire logic [7:0]            pin_oe_n_i,
    output var  logic [7:0]            pin_in_o,
    output var  glp_pkg::glp_alt_out_s alt_out_o
);
    initial begin
        pin_in_o = 8'h00;
        alt_out_o = 4'hf;
    end
    // Released pads never keep the block's last level: they take the outside level
    always @(posedge core_clk_i) begin
        pin_in_o <= (pin_out_i & ~pin_oe_n_i) | (ext_level_i & pin_oe_n_i);
        alt_out_o <= periph_i;
    end
endmodule // glp_pad_model
`default_nettype wire

// [dv/test_gpio_low_pin_function_select.sv]
// Self-checking bench for the low pin function select block, APB master plus pad model.
// Assumes the checker is bound below; xorshift stimulus from a fixed start.
`timescale 1ns/1ps
`default_nettype none
module test_gpio_low_pin_function_select;
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  rtc = 1'b1;
    glp_pkg::glp_apb_req_s req = '0;
    logic                  rdy, err, e;
    logic [31:0]           rdat, rd, r;
    logic [31:0]           seed = 32'h0000_004b;
    logic [7:0]            pin_in, pin_out, oe_n, gp_in;
    logic [7:0]            gp_out = 8'h00;
    logic [7:0]            ext = 8'h00;
    logic [3:0]            per = 4'hf;
    glp_pkg::glp_alt_out_s alt_out;
    glp_pkg::glp_alt_in_s  alt_in;
    logic [15:0]           mode;
    logic [15:0]           scr [16];
    int                    fail_count = 0;
    int                    n_checks = 0;
    localparam logic [31:0] MA = {2'b00, glp_pkg::GLP_MODE_IDX, 2'b00};

    always #10 clk = ~clk;

    glp_pin_function_select i_dut (
        .core_clk_i(clk), .reset_i(rst), .rtc_domain_reset_i(rtc), .apb_req_i(req),
        .pready_o(rdy), .prdata_o(rdat), .pslverr_o(err), .pin_in_i(pin_in),
        .pin_out_o(pin_out), .pin_oe_n_o(oe_n), .gp_out_data_i(gp_out),
        .gp_in_data_o(gp_in), .alt_out_i(alt_out), .alt_in_o(alt_in));
    glp_pad_model i_pads (
        .core_clk_i(clk), .ext_level_i(ext), .periph_i(per), .pin_out_i(pin_out),
        .pin_oe_n_i(oe_n), .pin_in_o(pin_in), .alt_out_o(alt_out));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected enables, levels and peripheral inputs for a mode word
    function automatic logic [18:0] exp_pins(input logic [15:0] m);
        logic [7:0] oe, o, alt, mk;
        alt = {per[3], per[2], 2'b00, per[1], 1'b0, per[0], 1'b0};
        mk = 8'hca;
        for (int n = 0; n < 8; n++) begin
            oe[n] = !(m[2*n+:2] == 2'h2 || (m[2*n+:2] == 2'h3 && mk[n]));
            o[n] = (m[2*n+:2] == 2'h2) ? gp_out[n] : (m[2*n+:2] == 2'h3 && mk[n]) ? alt[n] : 1'b0;
        end
        return {oe, o, (m[11:10] == 2'h1) ? pin_in[5] : 1'b1, (m[5:4] == 2'h1) & pin_in[2], (m[1:0] == 2'h1) & pin_in[0]};
    endfunction

    task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One APB transfer; request held until ready is sampled high
    task automatic apb(input logic w, input logic [31:0] a, input logic [15:0] d, input logic [3:0] s);
        int k;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, {16'h0000, d}, s};
        @(posedge clk);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (rdy !== 1'b1 && k < 20);
        if (rdy !== 1'b1) begin
            fail_count++;
            give_verdict();
        end else begin
            rd = rdat;
            e = err;
            req.psel <= 1'b0;
            req.penable <= 1'b0;
        end
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rtc <= 1'b0;
        apb(1'b0, MA, 16'h0000, 4'hf);
        check("mode_after_rtc", 32'h0000_0000, rd);
        check("oe_after_rtc", 32'h0000_00ff, {24'h00_0000, oe_n});
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            r = xs();
            scr[i] = r[15:0];
            apb(1'b1, {2'b00, glp_pkg::GLP_SCRATCH_IDX[i], 2'b00}, scr[i], 4'h3);
        end
        r = xs();
        mode = r[15:0];
        apb(1'b1, MA, mode, 4'h3);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, MA, 16'h0000, 4'hf);
        check("mode_kept", {16'h0000, mode}, rd);
        for (int i = 0; i < 16; i++) begin
            apb(1'b0, {2'b00, glp_pkg::GLP_SCRATCH_IDX[i], 2'b00}, 16'h0000, 4'hf);
            check("scratch", {16'h0000, scr[i]}, rd);
        end
        $display("test scratch done");
        // Every code on every pin first, then random mixes with reserved codes among them
        for (int k = 0; k < 28; k++) begin
            r = xs();
            mode = (k < 4) ? {8{k[1:0]}} : r[15:0];
            gp_out <= r[23:16];
            ext <= r[31:24];
            per <= r[11:8];
            apb(1'b1, MA, mode, 4'h3);
            repeat (6) @(posedge clk);
            check("pins", {13'h0000, exp_pins(mode)}, {13'h0000, oe_n, pin_out, alt_in});
            check("gp_in", {24'h00_0000, pin_in}, {24'h00_0000, gp_in});
            apb(1'b0, MA, 16'h0000, 4'hf);
            check("mode_readback", {16'h0000, mode}, rd);
        end
        $display("test pin functions done");
        apb(1'b1, MA + 32'h0000_0004, 16'hffff, 4'h3);
        check("unmapped_err", 32'h0000_0001, {31'h0000_0000, e});
        apb(1'b1, MA, 16'hffff, 4'h1);
        apb(1'b0, MA, 16'h0000, 4'hf);
        check("low_byte_only", {16'h0000, mode[15:8], 8'hff}, rd);
        apb(1'b1, {2'b00, glp_pkg::GLP_SCRATCH_IDX[3], 2'b00}, 16'h0000, 4'h2);
        apb(1'b0, {2'b00, glp_pkg::GLP_SCRATCH_IDX[3], 2'b00}, 16'h0000, 4'hf);
        check("scratch_high_byte", {16'h0000, 8'h00, scr[3][7:0]}, rd);
        $display("test refusals done");
        // Mid-run RTC reset: pins back to inputs, mode and scratch cleared
        rtc <= 1'b1;
        repeat (3) @(posedge clk);
        rtc <= 1'b0;
        apb(1'b0, MA, 16'h0000, 4'hf);
        check("mode_rtc_clear", {16'h0000, glp_pkg::GLP_MODE_RESET}, rd);
        check("oe_rtc_clear", 32'h0000_00ff, {24'h00_0000, oe_n});
        apb(1'b0, {2'b00, glp_pkg::GLP_SCRATCH_IDX[3], 2'b00}, 16'h0000, 4'hf);
        check("scratch_rtc_clear", {16'h0000, glp_pkg::GLP_SCRATCH_RESET}, rd);
        $display("test rtc reset done");
        give_verdict();
    end
endmodule // test_gpio_low_pin_function_select

bind glp_pin_function_select glp_props i_props (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .rtc_domain_reset_i(rtc_domain_reset_i),
    .apb_req_i(apb_req_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o), .gp_out_data_i(gp_out_data_i),
    .gp_in_data_o(gp_in_data_o), .alt_out_i(alt_out_i), .alt_in_o(alt_in_o));
`default_nettype wire
